/* rtl/codec_coefficient_programming.sv */
// command decoder, direct access and coefficient back-up for the codec
// Contract
// - each command is followed by 0, 1, 4, 5 or 8 data bytes, any order
// - coefficient ops 0..2 carry eight tone generator bytes each
// - coefficient op 3 carries four tone filter bytes in sequence order
// - sixteen coefficient ops, each block readable and writable
// - extended op 6 moves register plus four RAM bytes; op F is no-op
// - registers 60h-6Fh and coefficient RAM 80h-FFh reachable directly
// - back-up keeps processor on a consistent block during direct changes
// - block select, access select, start and busy steer back-up
// - coefficient RAM split into sixteen blocks by four-bit address
// - blocks are eight bytes, laid out as the operation sequences
// - access select 0 uses normal RAM, 1 uses temporary block; a command write serves its block from the temporary block at 0 as well
// - start copies selected block into temporary block
// - busy is 1 while a copy runs, else 0
// - command writes to coefficients back up the block automatically
`timescale 1ns/1ps
`include "codec_prog_map.svh"
module codec_coefficient_programming (
  input wire logic core_clk,
  input wire logic rst,
  // command byte stream
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // direct access
  input wire codec_prog_pkg::dir_req_s dir_req,
  // read answers
  output logic out_valid,
  output logic [7:0] out_data,
  // back-up control and status bits
  input wire logic [3:0] block_address,
  input wire logic processor_access_select,
  input wire logic backup_start,
  output logic backup_busy,
  // signal processor coefficient port
  input wire logic [6:0] dsp_addr,
  output logic [7:0] dsp_rdata,
  // configuration register contents
  output logic [15:0][7:0] cfg_regs
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COPY,
    ST_WDATA,
    ST_RDATA
  } seq_state_e;

  // ----------------------------------------
  // decoding functions
  // ----------------------------------------
  // split the command word into its fields
  function automatic codec_prog_pkg::cmd_s decode_cmd(input logic [7:0] w);
    codec_prog_pkg::cmd_s c;
    c.rd = w[`CMD_RW_BIT];
    c.cls = codec_prog_pkg::op_class_e'(w[`CMD_CLS_HI:`CMD_CLS_LO]);
    c.op = w[`CMD_OP_HI:`CMD_OP_LO];
    return c;
  endfunction : decode_cmd

  // number of data bytes behind each command
  function automatic logic [3:0] data_len(input codec_prog_pkg::cmd_s c);
    logic [3:0] n;
    n = `LEN_NONE;
    case (c.cls)
      codec_prog_pkg::CLS_STATUS: begin
        n = (c.op == `OP_LAST) ? `LEN_BLOCK : `LEN_ONE;
      end
      // short coefficient sequences carry four bytes
      codec_prog_pkg::CLS_COEFF: begin
        if (c.op == `COP_TONE_FILTER || c.op == `COP_CONTROL_GEN || c.op == `COP_SIDETONE) begin
          n = `LEN_SHORT;
        end else begin
          n = `LEN_BLOCK;
        end
      end
      // volume sequence five bytes, no-op none
      codec_prog_pkg::CLS_EXTENDED: begin
        n = (c.op == `XOP_VOLUME) ? `LEN_VOLUME : `LEN_NONE;
      end
      default: begin
        n = `LEN_NONE;
      end
    endcase
    return n;
  endfunction : data_len

  // location of data byte idx of a sequence
  function automatic codec_prog_pkg::loc_s seq_loc(input codec_prog_pkg::cmd_s c, input logic [3:0] idx);
    codec_prog_pkg::loc_s l;
    l.is_cram = 1'b0;
    l.addr = `REG_BASE;
    case (c.cls)
      codec_prog_pkg::CLS_STATUS: begin
        l.addr = `REG_BASE + {4'h0, (c.op == `OP_LAST) ? idx : c.op};
      end
      // op n maps onto block n, bytes in order
      codec_prog_pkg::CLS_COEFF: begin
        l.is_cram = 1'b1;
        l.addr = {1'b1, c.op, idx[2:0]};
      end
      // register first, then four RAM bytes
      codec_prog_pkg::CLS_EXTENDED: begin
        l.is_cram = (idx != 4'h0);
        l.addr = (idx == 4'h0) ? `VOLUME_REG_ADDR : `VOLUME_CRAM_ADDR + {4'h0, idx - 4'h1};
      end
      default: begin
        l.is_cram = 1'b0;
      end
    endcase
    return l;
  endfunction : seq_loc

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic [7:0] cram [0:127];
  seq_state_e state_reg;
  seq_state_e state_next;
  codec_prog_pkg::cmd_s cmd_reg;
  codec_prog_pkg::cmd_s cmd_in;
  logic [3:0] cnt_reg;
  logic [3:0] len_reg;
  logic [3:0] len_in;
  logic auto_dca_reg;
  logic byte_take;
  logic dir_take;
  logic auto_start;
  logic [3:0] auto_block;
  logic cp_done;
  logic [3:0] cp_block;
  logic [6:0] cp_addr;
  logic [7:0] tmp_rdata;
  codec_prog_pkg::loc_s cur_loc;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic use_tmp;

  assign cmd_in = decode_cmd(in_data);
  assign len_in = data_len(cmd_in);
  assign byte_take = in_valid && in_ready;
  // stream byte wins; direct access only while no sequence runs
  assign dir_take = dir_req.req && state_reg == ST_IDLE && !byte_take;
  assign cur_loc = seq_loc(cmd_reg, cnt_reg);
  // coefficient writes by command start their own copy
  // the volume sequence rewrites ram too, so its block is protected as well
  assign auto_start = state_reg == ST_IDLE && byte_take && !cmd_in.rd
    && (cmd_in.cls == codec_prog_pkg::CLS_COEFF
    || (cmd_in.cls == codec_prog_pkg::CLS_EXTENDED && cmd_in.op == `XOP_VOLUME));
  assign auto_block = (cmd_in.cls == codec_prog_pkg::CLS_COEFF) ? cmd_in.op : `VOLUME_BLOCK;

  // ----------------------------------------
  // back-up engine
  // ----------------------------------------
  // host start or automatic start share one engine
  cram_backup u_backup (
    .core_clk(core_clk),
    .rst(rst),
    .start(backup_start || auto_start),
    .block_address(auto_start ? auto_block : block_address),
    .cram_rdata(cram[cp_addr]),
    .tmp_idx(dsp_addr[2:0]),
    .cram_raddr(cp_addr),
    .tmp_rdata(tmp_rdata),
    .held_block(cp_block),
    .busy(backup_busy),
    .done(cp_done)
  );

  // ----------------------------------------
  // sequence control
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (byte_take && len_in != `LEN_NONE) begin
          if (cmd_in.rd) begin
            state_next = ST_RDATA;
          end else if (auto_start) begin
            state_next = ST_COPY;
          end else begin
            state_next = ST_WDATA;
          end
        end
      end
      ST_COPY: begin
        if (cp_done) begin
          state_next = ST_WDATA;
        end
      end
      ST_WDATA: begin
        if (byte_take && cnt_reg == len_reg - 4'h1) begin
          state_next = ST_IDLE;
        end
      end
      ST_RDATA: begin
        if (cnt_reg == len_reg - 4'h1) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // any order, fixed byte count per command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= '0;
      len_reg <= `LEN_NONE;
      cnt_reg <= 4'h0;
      in_ready <= 1'b1;
    end else begin
      state_reg <= state_next;
      // stalls the stream while a copy runs outside a write sequence or a read is answered;
      // an auto start during a host copy would otherwise be dropped
      in_ready <= state_next == ST_WDATA || (state_next == ST_IDLE && !backup_busy && !backup_start);
      if (state_reg == ST_IDLE && byte_take) begin
        cmd_reg <= cmd_in;
        len_reg <= len_in;
        cnt_reg <= 4'h0;
      end else if ((state_reg == ST_WDATA && byte_take) || state_reg == ST_RDATA) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  // processor kept on the copy while a command rewrites a block
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      auto_dca_reg <= 1'b0;
    end else if (state_reg == ST_COPY && cp_done) begin
      auto_dca_reg <= 1'b1;
    end else if (state_next == ST_IDLE) begin
      auto_dca_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // write and read ports
  // ----------------------------------------
  // one write per cycle, from the stream or a direct access
  always_comb begin
    wr_en = 1'b0;
    wr_addr = cur_loc.addr;
    wr_data = in_data;
    rd_addr = cur_loc.addr;
    if (state_reg == ST_WDATA && byte_take) begin
      wr_en = 1'b1;
    end else if (dir_take) begin
      wr_en = dir_req.we;
      wr_addr = dir_req.addr;
      wr_data = dir_req.wdata;
      rd_addr = dir_req.addr;
    end
  end

  // unmapped addresses read zero
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr[7]) begin
      rd_data = cram[rd_addr[6:0]];
    end else if (rd_addr >= `REG_BASE && rd_addr <= `REG_LAST) begin
      rd_data = cfg_regs[rd_addr[3:0]];
    end
  end

  // sixteen blocks of eight bytes each
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 128; i++) begin
        cram[i] <= `CRAM_RESET;
      end
    end else if (wr_en && wr_addr[7]) begin
      cram[wr_addr[6:0]] <= wr_data;
    end
  end

  // configuration registers; writes outside the map are dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        cfg_regs[i] <= `CFG_RESET;
      end
    end else if (wr_en && wr_addr >= `REG_BASE && wr_addr <= `REG_LAST) begin
      cfg_regs[wr_addr[3:0]] <= wr_data;
    end
  end

  // read answers: one byte per cycle for sequences
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
    end else begin
      out_valid <= state_reg == ST_RDATA || (dir_take && !dir_req.we);
      out_data <= rd_data;
    end
  end

  // ----------------------------------------
  // signal processor view
  // ----------------------------------------
  // the held block is served from the temporary copy while access select or a command write holds it
  assign use_tmp = (processor_access_select || auto_dca_reg) && dsp_addr[6:3] == cp_block;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dsp_rdata <= 8'h00;
    end else begin
      dsp_rdata <= use_tmp ? tmp_rdata : cram[dsp_addr];
    end
  end

endmodule : codec_coefficient_programming

/* rtl/codec_prog_map.svh */
// address map, field positions, codes and counts of the coefficient programming block
`ifndef CODEC_PROG_MAP_SVH
`define CODEC_PROG_MAP_SVH

// command word fields
`define CMD_RW_BIT 7
`define CMD_CLS_HI 5
`define CMD_CLS_LO 4
`define CMD_OP_HI 3
`define CMD_OP_LO 0

// operation codes inside a class
`define OP_LAST 4'hF
`define COP_TONE_FILTER 4'h3
`define COP_CONTROL_GEN 4'h4
`define COP_SIDETONE 4'h6
`define XOP_VOLUME 4'h6
`define XOP_NOP 4'hF

// data byte counts that follow a command word
`define LEN_NONE 4'h0
`define LEN_ONE 4'h1
`define LEN_SHORT 4'h4
`define LEN_VOLUME 4'h5
`define LEN_BLOCK 4'h8

// direct address map
`define REG_BASE 8'h60
`define REG_LAST 8'h6F
`define CRAM_BASE 8'h80
`define CRAM_LAST 8'hFF
`define VOLUME_REG_ADDR 8'h66
`define VOLUME_CRAM_ADDR 8'hB8
`define VOLUME_BLOCK 4'h7

// reset values
`define CFG_RESET 8'h00
`define CRAM_RESET 8'h00
`define BLOCK_BYTES 4'h8

`endif

/* rtl/codec_prog_pkg.sv */
// types shared by the coefficient programming block
package codec_prog_pkg;

  typedef enum logic [1:0] {
    CLS_RESERVED,
    CLS_STATUS,
    CLS_COEFF,
    CLS_EXTENDED
  } op_class_e;

  // decoded command word
  typedef struct packed {
    logic rd;
    op_class_e cls;
    logic [3:0] op;
  } cmd_s;

  // one direct access request
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dir_req_s;

  // one location of the address map
  typedef struct packed {
    logic is_cram;
    logic [7:0] addr;
  } loc_s;

endpackage : codec_prog_pkg

/* rtl/cram_backup.sv */
// block copy engine and temporary eight-byte coefficient block
`timescale 1ns/1ps
`include "codec_prog_map.svh"
module cram_backup (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] block_address,
  input wire logic [7:0] cram_rdata,
  input wire logic [2:0] tmp_idx,
  output logic [6:0] cram_raddr,
  output logic [7:0] tmp_rdata,
  output logic [3:0] held_block,
  output logic busy,
  output logic done
);

  logic [7:0] tmp_mem [0:7];
  logic [2:0] cnt_reg;

  assign cram_raddr = {held_block, cnt_reg};
  assign tmp_rdata = tmp_mem[tmp_idx];

  // ----------------------------------------
  // copy sequencer
  // ----------------------------------------
  // start copies selected block; a start while busy is dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt_reg <= 3'h0;
      held_block <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        cnt_reg <= 3'h0;
        held_block <= block_address;
      end else if (busy) begin
        cnt_reg <= cnt_reg + 3'h1;
        // busy clears after the last byte
        if (cnt_reg == 3'h7) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // temporary block storage
  // ----------------------------------------
  // one byte per cycle, eight cycles a block
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        tmp_mem[i] <= `CRAM_RESET;
      end
    end else if (busy) begin
      tmp_mem[cnt_reg] <= cram_rdata;
    end
  end

endmodule : cram_backup

/* dv/codec_prog_checker_assertions.sv */
// port checker for the coefficient programming block
`timescale 1ns/1ps
module codec_prog_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire codec_prog_pkg::dir_req_s dir_req,
  input wire logic out_valid,
  input wire logic backup_start,
  input wire logic backup_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // copy engine runs exactly one byte per cycle
  chk_busy_len: assert property ($rose(backup_busy) |-> backup_busy[*8] ##1 !backup_busy)
    else $error("busy length wrong");
  chk_start_busy: assert property (backup_start && !backup_busy |=> backup_busy)
    else $error("start not taken");
  chk_busy_cause: assert property ($rose(backup_busy) |-> $past(backup_start) || $past(in_valid && in_ready))
    else $error("busy without cause");
  chk_auto_stall: assert property ($rose(backup_busy) && !$past(backup_start) |-> !in_ready[*8])
    else $error("stream open during copy");
  chk_out_cause: assert property (out_valid |-> $past(out_valid) || $past(dir_req.req) || $past(in_valid && in_ready, 2))
    else $error("answer without request");
  chk_answer_stall: assert property ($rose(out_valid) && !$past(dir_req.req) |-> !$past(in_ready))
    else $error("stream open before answer");
  chk_answer_end: assert property ($fell(out_valid) |-> in_ready)
    else $error("stream closed after answer");
  chk_reset_quiet: assert property ($fell(rst) |-> in_ready && !backup_busy && !out_valid)
    else $error("outputs wrong after reset");
  // main scenarios reached
  cov_manual_copy: cover property ($rose(backup_busy) && $past(backup_start));
  cov_auto_copy: cover property ($rose(backup_busy) && !$past(backup_start));
  cov_long_read: cover property (out_valid[*4]);
endmodule : codec_prog_checker
bind codec_coefficient_programming codec_prog_checker codec_prog_checker_inst (.core_clk, .rst, .in_valid,
  .in_ready, .dir_req, .out_valid, .backup_start, .backup_busy);

/* dv/codec_prog_host.sv */
// host model: command stream, direct accesses and back-up bits
`timescale 1ns/1ps
module codec_prog_host (
  input wire logic core_clk,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic backup_busy,
  output logic in_valid,
  output logic [7:0] in_data,
  output codec_prog_pkg::dir_req_s dir_req,
  output logic [3:0] block_address,
  output logic processor_access_select,
  output logic backup_start
);
  // idle levels at time zero
  initial begin
    in_valid = 1'b0;
    in_data = 8'hA5;
    dir_req = '{req: 1'b0, we: 1'b0, addr: 8'h00, wdata: 8'h00};
    block_address = 4'h0;
    processor_access_select = 1'b0;
    backup_start = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    in_data = b;
    in_valid = 1'b1;
    while (in_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
  endtask : send
  // released data flips so a stale byte never looks valid
  task automatic idle();
    in_valid = 1'b0;
    in_data = ~in_data;
  endtask : idle
  task automatic dacc(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    while (backup_busy !== 1'b0) @(negedge core_clk);
    dir_req = '{req: 1'b1, we: we, addr: a, wdata: d};
    @(negedge core_clk);
    q = (!we && out_valid !== 1'b1) ? 8'hXX : out_data;
    dir_req = '{req: 1'b0, we: ~we, addr: ~a, wdata: ~d};
    @(negedge core_clk);
  endtask : dacc
  // copy block then wait for the engine
  task automatic backup(input logic [3:0] blk);
    block_address = blk;
    backup_start = 1'b1;
    @(negedge core_clk);
    backup_start = 1'b0;
    while (backup_busy !== 1'b0) @(negedge core_clk);
  endtask : backup
endmodule : codec_prog_host

/* dv/codec_coefficient_programming_bench.sv */
// self-checking bench for the coefficient programming block
`timescale 1ns/1ps
module codec_coefficient_programming_bench;
  logic core_clk, rst, in_valid, in_ready, out_valid, sel, start, busy;
  logic [7:0] in_data, out_data, dsp_rdata, q;
  logic [3:0] blk;
  logic [6:0] dsp_addr;
  logic [15:0][7:0] cfg_regs;
  logic [7:0] got [8];
  codec_prog_pkg::dir_req_s dir_req;
  int err_count = 0;
  int n_tests = 0;
  codec_coefficient_programming codec_coefficient_programming_inst (.core_clk(core_clk), .rst(rst),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .dir_req(dir_req), .out_valid(out_valid),
    .out_data(out_data), .block_address(blk), .processor_access_select(sel), .backup_start(start),
    .backup_busy(busy), .dsp_addr(dsp_addr), .dsp_rdata(dsp_rdata), .cfg_regs(cfg_regs));
  codec_prog_host codec_prog_host_inst (.core_clk(core_clk), .in_ready(in_ready), .out_valid(out_valid),
    .out_data(out_data), .backup_busy(busy), .in_valid(in_valid), .in_data(in_data), .dir_req(dir_req),
    .block_address(blk), .processor_access_select(sel), .backup_start(start));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  // -------------------------------------------------
  // transfer helpers
  // -------------------------------------------------
  task automatic wr(input logic [7:0] cmd, input int n, input logic [7:0] base);
    codec_prog_host_inst.send(cmd);
    for (int i = 0; i < n; i++) codec_prog_host_inst.send(base + 8'(i));
    codec_prog_host_inst.idle();
  endtask : wr
  // answer bytes gathered under a bound
  task automatic rd(input logic [7:0] cmd, input int n);
    int k;
    k = 0;
    got = '{default: 8'hXX};
    codec_prog_host_inst.send(cmd);
    codec_prog_host_inst.idle();
    for (int w = 0; w < 20 && k < n; w++) begin
      if (out_valid === 1'b1) begin
        got[k] = out_data;
        k++;
      end
      @(negedge core_clk);
    end
  endtask : rd
  task automatic dchk(input logic [7:0] a, input logic [7:0] exp);
    codec_prog_host_inst.dacc(1'b0, a, 8'h00, q);
    check("direct read", q, exp);
  endtask : dchk
  task automatic dsp(input logic [6:0] a, input logic [7:0] exp);
    dsp_addr = a;
    @(negedge core_clk);
    check("dsp_rdata", dsp_rdata, exp);
  endtask : dsp
  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic t_status();
    wr(8'h15, 1, 8'h5A);
    check("cfg 65h", cfg_regs[5], 8'h5A);
    rd(8'h95, 1);
    check("read 65h", got[0], 8'h5A);
    wr(8'h1F, 8, 8'h30);
    rd(8'h9F, 8);
    for (int i = 0; i < 8; i++) check("status all", got[i], 8'h30 + 8'(i));
  endtask : t_status
  // every coefficient op written then read back both ways
  task automatic t_cop();
    int n;
    for (int op = 0; op < 16; op++) begin
      n = (op == 3 || op == 4 || op == 6) ? 4 : 8;
      wr({4'h2, 4'(op)}, n, {4'(op), 4'h0});
      rd({4'hA, 4'(op)}, n);
      for (int i = 0; i < n; i++) begin
        check("cop read", got[i], {4'(op), 4'(i)});
        dchk(8'h80 + 8'(op * 8 + i), {4'(op), 4'(i)});
      end
    end
  endtask : t_cop
  task automatic t_volume();
    wr(8'h36, 5, 8'hC0);
    check("volume reg", cfg_regs[6], 8'hC0);
    for (int i = 0; i < 4; i++) dchk(8'hB8 + 8'(i), 8'hC1 + 8'(i));
    codec_prog_host_inst.send(8'h3F);
    // reserved class takes no data either
    codec_prog_host_inst.send(8'h05);
    wr(8'h17, 1, 8'h77);
    check("after nop", cfg_regs[7], 8'h77);
  endtask : t_volume
  task automatic t_direct();
    codec_prog_host_inst.dacc(1'b1, 8'h6F, 8'hA5, q);
    check("cfg 6Fh", cfg_regs[15], 8'hA5);
    dchk(8'h6F, 8'hA5);
    codec_prog_host_inst.dacc(1'b1, 8'h70, 8'h11, q);
    dchk(8'h70, 8'h00);
    codec_prog_host_inst.dacc(1'b1, 8'hFF, 8'h3C, q);
    dchk(8'hFF, 8'h3C);
  endtask : t_direct
  // copy block 2, steer processor to the copy, change the RAM block, steer back
  task automatic t_backup();
    for (int i = 0; i < 8; i++) codec_prog_host_inst.dacc(1'b1, 8'h90 + 8'(i), 8'hE0 + 8'(i), q);
    dsp(7'h10, 8'hE0);
    codec_prog_host_inst.backup(4'h2);
    check("busy after copy", {7'h00, busy}, 8'h00);
    codec_prog_host_inst.processor_access_select = 1'b1;
    codec_prog_host_inst.dacc(1'b1, 8'h90, 8'h55, q);
    dsp(7'h10, 8'hE0);
    dsp(7'h17, 8'hE7);
    dsp(7'h18, 8'h30);
    codec_prog_host_inst.processor_access_select = 1'b0;
    dsp(7'h10, 8'h55);
  endtask : t_backup
  // clock at 10 MHz
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    dsp_addr = 7'h00;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check("in_ready", {7'h00, in_ready}, 8'h01);
    for (int i = 0; i < 16; i++) check("cfg reset", cfg_regs[i], 8'h00);
    t_status();
    t_cop();
    t_volume();
    t_direct();
    t_backup();
    summarize();
  end
endmodule : codec_coefficient_programming_bench
